// >>> bench/lsvf_grab.sv
`timescale 1ns/100ps
`default_nettype none
module lsvf_grab (
  input  wire logic        pclk_i,
  input  wire logic [11:0] pix_idx_i,
  input  wire logic [29:0] key_i,
  input  wire logic [7:0]  tx_a_i,
  input  wire logic [7:0]  tx_b_i,
  input  wire logic [7:0]  tx_c_i,
  input  wire logic        lval_i,
  output logic      [9:0]  red_o,
  output logic      [9:0]  grn_o,
  output logic      [9:0]  blu_o,
  output logic             rx_stb_o,
  output logic      [23:0] rx_dat_o
);
  // corrected line store, keyed per line
  assign red_o = pix_idx_i[9:0] ^ key_i[9:0];
  assign grn_o = pix_idx_i[9:0] ^ key_i[19:10];
  assign blu_o = pix_idx_i[9:0] ^ key_i[29:20];
  // rising-edge capture, fields only with lval
  always_ff @(posedge pclk_i) begin
    rx_stb_o <= lval_i;
    rx_dat_o <= lval_i ? {tx_a_i, tx_b_i, tx_c_i} : 24'h0;
  end
endmodule // lsvf_grab
`default_nettype wire

// >>> bench/lsvf_props.sv
`timescale 1ns/100ps
`default_nettype none
module lsvf_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        pclk_i,
  input wire logic [1:0]  pclk_sel_o,
  input wire logic [7:0]  tx_a_o,
  input wire logic [7:0]  tx_b_o,
  input wire logic [7:0]  tx_c_o,
  input wire logic        lval_o
);
  // -------------------------------
  // line-valid run length
  // -------------------------------
  logic [12:0] run_ff;
  always_ff @(posedge pclk_i) begin
    if (rst_i) run_ff <= 13'h0000;
    else run_ff <= lval_o ? run_ff + 13'h0001 : 13'h0000;
  end
  ack_pulse_a:
    assert property (@(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_resp_a:
    assert property (@(posedge clk_i) disable iff (rst_i) wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  ack_cause_a:
    assert property (@(posedge clk_i) disable iff (rst_i) wb_ack_o |-> $past(wb_stb_i)) else $error("stray ack");
  unmapped_zero_a:
    assert property (@(posedge clk_i) disable iff (rst_i) wb_ack_o && wb_adr_i >= 8'h0C |-> wb_dat_o == 32'h0)
    else $error("unmapped data not zero");
  rst_quiet_a:
    assert property (@(posedge clk_i) disable iff (rst_i) $fell(rst_i) |-> !lval_o && !wb_ack_o && tx_a_o == 8'h00)
    else $error("outputs active after reset");
  idle_zero_a:
    assert property (@(posedge pclk_i) disable iff (rst_i) !lval_o |-> {tx_a_o, tx_b_o, tx_c_o} == 24'h0)
    else $error("fields not zero while idle");
  single_fields_a:
    assert property (@(posedge pclk_i) disable iff (rst_i)
      lval_o && pclk_sel_o == lsvf_pkg::PCLK_60MHZ |-> tx_b_o[7:2] == 6'h00 && tx_c_o == 8'h00)
    else $error("single mode spare bits set");
  rgb_len_a:
    assert property (@(posedge pclk_i) disable iff (rst_i)
      lval_o && pclk_sel_o == lsvf_pkg::PCLK_20MHZ |-> run_ff < 13'h0832) else $error("rgb line too long");
  single_len_a:
    assert property (@(posedge pclk_i) disable iff (rst_i) lval_o |-> run_ff < 13'h1896) else $error("line too long");
endmodule // lsvf_props
bind lsvf_top lsvf_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pclk_i(pclk_i), .pclk_sel_o(pclk_sel_o),
  .tx_a_o(tx_a_o), .tx_b_o(tx_b_o), .tx_c_o(tx_c_o), .lval_o(lval_o));
`default_nettype wire

// >>> bench/lsvf_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; $display("[FAIL] %0t %h %h", $time, g, e); end end
module lsvf_tb_top;
  logic        clk_i = 1'b0, pclk = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, done = 1'b0, ack, lval, rx_stb;
  logic [7:0]  adr = 8'h00, ta, tb, tc;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat;
  logic [29:0] key = 30'h0;
  logic [9:0]  r, g, b;
  logic [11:0] idx;
  logic [1:0]  psel;
  logic [23:0] rx_dat, dq[$];
  logic [31:0] rq[$];
  int          seed = 91344, bad_count = 0, check_count = 0;
  always #50 clk_i = ~clk_i;
  // link clock offset so its edges never meet the system clock's
  initial begin
    #7;
    forever #24 pclk = ~pclk;
  end
  lsvf_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .line_done_i(done), .pclk_sel_o(psel),
    .pclk_i(pclk), .pix_idx_o(idx), .pix_red_i(r), .pix_grn_i(g), .pix_blu_i(b), .tx_a_o(ta), .tx_b_o(tb),
    .tx_c_o(tc), .lval_o(lval));
  lsvf_grab u_grab (.pclk_i(pclk), .pix_idx_i(idx), .key_i(key), .tx_a_i(ta), .tx_b_i(tb), .tx_c_i(tc),
    .lval_i(lval), .red_o(r), .grn_o(g), .blu_o(b), .rx_stb_o(rx_stb), .rx_dat_o(rx_dat));
  // -------------------------------
  // result monitors
  // -------------------------------
  logic [31:0] rexp;
  logic [23:0] dexp;
  // read data taken at the edge that sees ack
  always @(posedge clk_i) begin
    if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0) begin
      rexp = rq.pop_front();
      `CHK(rdat, rexp)
    end
  end
  always @(negedge pclk) begin
    if (rst_i === 1'b0 && rx_stb !== 1'b0) begin
      `CHK(dq.size() > 0, 1'b1)
      dexp = dq.pop_front();
      `CHK(rx_dat, dexp)
    end
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    wb(1'b0, a, 32'h0, 4'hF);
  endtask
  task automatic line(input logic [2:0] m, input int len, input logic dbl);
    logic [29:0] k;
    logic [9:0]  s;
    logic [23:0] e;
    int          n;
    k = 30'($random(seed));
    for (int i = 0; i < len; i++) begin
      for (int c = 0; c < 3; c++) begin
        s = 10'(i) ^ k[c*10 +: 10];
        e[(2-c)*8 +: 8] = s[9:2];
        if (m == lsvf_pkg::MODE_SP10) dq.push_back({s[7:0], 6'h00, s[9:8], 8'h00});
        if (m == lsvf_pkg::MODE_SP8) dq.push_back({s[9:2], 16'h0000});
      end
      if (m == lsvf_pkg::MODE_RGB8) dq.push_back(e);
    end
    @(posedge clk_i);
    key <= k;
    done <= 1'b1;
    @(posedge clk_i);
    done <= 1'b0;
    if (dbl) begin
      @(posedge clk_i);
      done <= 1'b1;
      @(posedge clk_i);
      done <= 1'b0;
    end
    n = 0;
    while (dq.size() > 0 && n++ < 8000) @(posedge clk_i);
    repeat (20) @(posedge clk_i);
    `CHK(dq.size(), 0)
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #1_000_000;
    bad_count++;
    results();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(lsvf_pkg::CTRL_OFS, 32'h0);
    rd(lsvf_pkg::AOI_OFS, 32'h832);
    rd(8'h0C, 32'h0);
    wb(1'b1, lsvf_pkg::AOI_OFS, 32'h0FFF, 4'h1);
    rd(lsvf_pkg::AOI_OFS, 32'h8FF);
    wb(1'b1, lsvf_pkg::CTRL_OFS, 32'h01, 4'hF);
    `CHK(psel, lsvf_pkg::PCLK_20MHZ)
    line(lsvf_pkg::MODE_RGB8, 2098, 1'b0);
    wb(1'b1, lsvf_pkg::AOI_OFS, 32'h1, 4'hF);
    wb(1'b1, lsvf_pkg::CTRL_OFS, 32'h11, 4'hF);
    line(lsvf_pkg::MODE_RGB8, 1, 1'b0);
    wb(1'b1, lsvf_pkg::AOI_OFS, 32'h5, 4'hF);
    wb(1'b1, lsvf_pkg::CTRL_OFS, 32'h13, 4'hF);
    `CHK(psel, lsvf_pkg::PCLK_60MHZ)
    line(lsvf_pkg::MODE_SP10, 5, 1'b1);
    rd(lsvf_pkg::STAT_OFS, 32'h0003_0002);
    wb(1'b1, lsvf_pkg::STAT_OFS, 32'h2, 4'hF);
    wb(1'b1, lsvf_pkg::CTRL_OFS, 32'h05, 4'hF);
    line(lsvf_pkg::MODE_SP8, 2098, 1'b0);
    for (int m = 3; m < 5; m++) begin
      wb(1'b1, lsvf_pkg::CTRL_OFS, 32'(m * 2 + 1), 4'hF);
      `CHK(psel, lsvf_pkg::PCLK_40MHZ)
      line(3'(m), 0, 1'b0);
    end
    wb(1'b1, lsvf_pkg::CTRL_OFS, 32'h0, 4'hF);
    line(lsvf_pkg::MODE_RGB8, 0, 1'b0);
    rd(lsvf_pkg::STAT_OFS, 32'h0004_0000);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(lsvf_pkg::STAT_OFS, 32'h0);
    repeat (2) @(posedge clk_i);
    results();
  end
endmodule // lsvf_tb_top
`default_nettype wire

// >>> design/lsvf_pkg.sv
`default_nettype none

package lsvf_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFS      = 8'h00;
  localparam logic [7:0]  AOI_OFS       = 8'h04;
  localparam logic [7:0]  STAT_OFS      = 8'h08;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int          CTRL_EN_POS   = 0;
  localparam int          CTRL_MODE_LSB = 1;
  localparam int          CTRL_AOI_POS  = 4;
  localparam int          STAT_BUSY_POS = 0;
  localparam int          STAT_OVR_POS  = 1;
  localparam int          STAT_CNT_LSB  = 16;

  // ---------------------------------------------------------------
  // mode codes
  // ---------------------------------------------------------------
  localparam logic [2:0]  MODE_RGB8     = 3'h0;
  localparam logic [2:0]  MODE_SP10     = 3'h1;
  localparam logic [2:0]  MODE_SP8      = 3'h2;
  localparam logic [2:0]  MODE_DP10     = 3'h3;
  localparam logic [2:0]  MODE_DP8      = 3'h4;

  // pixel clock rate select for the clock generator
  localparam logic [1:0]  PCLK_20MHZ    = 2'h0;
  localparam logic [1:0]  PCLK_60MHZ    = 2'h1;
  localparam logic [1:0]  PCLK_40MHZ    = 2'h2;

  // ---------------------------------------------------------------
  // line geometry and reset values
  // ---------------------------------------------------------------
  localparam int          IDX_W         = 12;
  localparam logic [11:0] LINE_PIX      = 12'h832;
  localparam logic        EN_RST        = 1'b0;
  localparam logic [2:0]  MODE_RST      = 3'h0;
  localparam logic        AOI_EN_RST    = 1'b0;
  localparam logic [11:0] AOI_LEN_RST   = 12'h832;

  typedef enum logic {LK_IDLE, LK_SEND} lsvf_lk_st_t;

endpackage

`default_nettype wire

// >>> design/lsvf_top.sv
// Notes on behaviour
// - five output modes selectable by software; only RGB8, SP10 and SP8 send lines
// - RGB mode requests 20 MHz pixel clock
// - RGB cycle carries red, green, blue bytes
// - outputs update on pixel clock falling edge
// - pixel fields valid only with line-valid high
// - line-valid low whenever no line is sent
// - send after acquisition; valid with first pixel
// - RGB line-valid lasts 2098 cycles, pixel n
// - line-valid drops right after last pixel
// - single-pixel modes 60 MHz, 10-bit samples
// - 8-bit mode drops two low bits
// - single-pixel order red, green, blue repeating
// - single-pixel line-valid lasts 6294 cycles
// - area-of-interest shortens the line
// - data comes from spatially corrected line store
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module lsvf_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        line_done_i,
  output logic      [1:0]  pclk_sel_o,
  input  wire logic        pclk_i,
  output logic      [11:0] pix_idx_o,
  input  wire logic [9:0]  pix_red_i,
  input  wire logic [9:0]  pix_grn_i,
  input  wire logic [9:0]  pix_blu_i,
  output logic      [7:0]  tx_a_o,
  output logic      [7:0]  tx_b_o,
  output logic      [7:0]  tx_c_o,
  output logic             lval_o
);

  // ---------------------------------------------------------------
  // system domain state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    logic        en;
    logic [2:0]  mode;
    logic        aoi_en;
    logic [11:0] aoi_len;
    logic        req_tgl;
    logic [2:0]  sh_mode;
    logic [11:0] sh_len;
    logic        ack_s1;
    logic        ack_s2;
    logic        ack_prev;
    logic        ovr;
    logic [15:0] lines;
  } lsvf_sys_t;

  lsvf_sys_t sys_ff;
  lsvf_sys_t nxt_sys;

  // ---------------------------------------------------------------
  // link domain state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                 rst_s1;
    logic                 rst_s2;
    logic                 req_s1;
    logic                 req_s2;
    logic                 req_prev;
    lsvf_pkg::lsvf_lk_st_t st;
    logic [2:0]           mode;
    logic [11:0]          len;
    logic [11:0]          idx;
    logic [1:0]           phase;
    logic                 ack_tgl;
    logic                 lval;
    logic [7:0]           a;
    logic [7:0]           b;
    logic [7:0]           c;
  } lsvf_lk_t;

  lsvf_lk_t lk_ff;
  lsvf_lk_t nxt_lk;

  logic        sys_busy;
  logic        mode_ok;
  logic        wb_hit;
  logic        aoi_ok;
  logic [11:0] eff_len;

  // ---------------------------------------------------------------
  // line handshake and bus strobe
  // ---------------------------------------------------------------
  // busy from request toggle until the returned toggle lands
  assign sys_busy = sys_ff.req_tgl != sys_ff.ack_s2;
  // ack blocks a second take while the master still holds stb
  assign wb_hit   = wb_cyc_i & wb_stb_i & ~sys_ff.ack;

  // ---------------------------------------------------------------
  // mode gate
  // ---------------------------------------------------------------
  // dual-pixel modes are selectable but not formatted here
  always_comb begin
    case (sys_ff.mode)
      lsvf_pkg::MODE_RGB8: mode_ok = 1'b1;
      lsvf_pkg::MODE_SP10: mode_ok = 1'b1;
      lsvf_pkg::MODE_SP8:  mode_ok = 1'b1;
      default:             mode_ok = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // area of interest
  // ---------------------------------------------------------------
  // area of interest, clamped to the full line
  assign aoi_ok  = sys_ff.aoi_en &&
                   (sys_ff.aoi_len != 12'h000) &&
                   (sys_ff.aoi_len < lsvf_pkg::LINE_PIX);
  assign eff_len = aoi_ok ? sys_ff.aoi_len : lsvf_pkg::LINE_PIX;

  // ---------------------------------------------------------------
  // wishbone slave, config, line request
  // ---------------------------------------------------------------
  always_comb begin
    nxt_sys          = sys_ff;
    nxt_sys.ack      = wb_hit;
    nxt_sys.ack_s1   = lk_ff.ack_tgl;
    nxt_sys.ack_s2   = sys_ff.ack_s1;
    nxt_sys.ack_prev = sys_ff.ack_s2;
    if (sys_ff.ack_s2 != sys_ff.ack_prev) begin
      nxt_sys.lines = sys_ff.lines + 16'h0001;
    end
    if (wb_hit) begin
      nxt_sys.dat = 32'h0000_0000;
      case (wb_adr_i)
        lsvf_pkg::CTRL_OFS: begin
          nxt_sys.dat[lsvf_pkg::CTRL_EN_POS]                          = sys_ff.en;
          nxt_sys.dat[lsvf_pkg::CTRL_MODE_LSB +: 3]                   = sys_ff.mode;
          nxt_sys.dat[lsvf_pkg::CTRL_AOI_POS]                         = sys_ff.aoi_en;
          if (wb_we_i && wb_sel_i[0]) begin
            nxt_sys.en     = wb_dat_i[lsvf_pkg::CTRL_EN_POS];
            nxt_sys.mode   = wb_dat_i[lsvf_pkg::CTRL_MODE_LSB +: 3];
            nxt_sys.aoi_en = wb_dat_i[lsvf_pkg::CTRL_AOI_POS];
          end
        end
        lsvf_pkg::AOI_OFS: begin
          nxt_sys.dat[11:0] = sys_ff.aoi_len;
          if (wb_we_i && wb_sel_i[0]) begin
            nxt_sys.aoi_len[7:0] = wb_dat_i[7:0];
          end
          if (wb_we_i && wb_sel_i[1]) begin
            nxt_sys.aoi_len[11:8] = wb_dat_i[11:8];
          end
        end
        lsvf_pkg::STAT_OFS: begin
          nxt_sys.dat[lsvf_pkg::STAT_BUSY_POS]     = sys_busy;
          nxt_sys.dat[lsvf_pkg::STAT_OVR_POS]      = sys_ff.ovr;
          nxt_sys.dat[lsvf_pkg::STAT_CNT_LSB +: 16] = sys_ff.lines;
          if (wb_we_i && wb_sel_i[0] && wb_dat_i[lsvf_pkg::STAT_OVR_POS]) begin
            nxt_sys.ovr = 1'b0;
          end
        end
        default: begin
          nxt_sys.dat = 32'h0000_0000;
        end
      endcase
    end
    // a finished acquisition starts a line
    if (line_done_i && sys_ff.en && mode_ok) begin
      if (sys_busy) begin
        // line lost while previous still sending; set beats clear
        nxt_sys.ovr = 1'b1;
      end else begin
        nxt_sys.req_tgl = ~sys_ff.req_tgl;
        nxt_sys.sh_mode = sys_ff.mode;
        nxt_sys.sh_len  = eff_len;
      end
    end
    if (rst_i) begin
      // register reset values
      nxt_sys          = '0;
      nxt_sys.en       = lsvf_pkg::EN_RST;
      nxt_sys.mode     = lsvf_pkg::MODE_RST;
      nxt_sys.aoi_en   = lsvf_pkg::AOI_EN_RST;
      nxt_sys.aoi_len  = lsvf_pkg::AOI_LEN_RST;
      nxt_sys.sh_len   = lsvf_pkg::LINE_PIX;
    end
  end

  // ---------------------------------------------------------------
  // system register and bus outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    sys_ff <= nxt_sys;
  end

  assign wb_ack_o = sys_ff.ack;
  assign wb_dat_o = sys_ff.dat;

  // ---------------------------------------------------------------
  // pixel clock rate request
  // ---------------------------------------------------------------
  // combinational so the generator follows the mode at once
  // rate request for the pixel clock generator
  // single-pixel modes ask for 60 MHz
  always_comb begin
    case (sys_ff.mode)
      lsvf_pkg::MODE_SP10: pclk_sel_o = lsvf_pkg::PCLK_60MHZ;
      lsvf_pkg::MODE_SP8:  pclk_sel_o = lsvf_pkg::PCLK_60MHZ;
      lsvf_pkg::MODE_DP10: pclk_sel_o = lsvf_pkg::PCLK_40MHZ;
      lsvf_pkg::MODE_DP8:  pclk_sel_o = lsvf_pkg::PCLK_40MHZ;
      default:             pclk_sel_o = lsvf_pkg::PCLK_20MHZ;
    endcase
  end

  // ---------------------------------------------------------------
  // link side formatter
  // ---------------------------------------------------------------
  logic        lk_last;
  logic        lk_pix_end;
  logic        lk_smp_end;
  logic [9:0]  lk_smp;

  // ---------------------------------------------------------------
  // colour sample select
  // ---------------------------------------------------------------
  always_comb begin
    case (lk_ff.phase)
      2'h1:    lk_smp = pix_grn_i;
      2'h2:    lk_smp = pix_blu_i;
      default: lk_smp = pix_red_i;
    endcase
  end

  // ---------------------------------------------------------------
  // end of line detect
  // ---------------------------------------------------------------
  // RGB ends after len pixels
  assign lk_pix_end = lk_ff.idx == lk_ff.len - 12'h001;
  // single-pixel ends after three samples per pixel
  assign lk_smp_end = (lk_ff.mode == lsvf_pkg::MODE_RGB8) || (lk_ff.phase == 2'h2);
  assign lk_last    = lk_pix_end && lk_smp_end;

  // ---------------------------------------------------------------
  // link next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_lk          = lk_ff;
    nxt_lk.rst_s1   = rst_i;
    nxt_lk.rst_s2   = lk_ff.rst_s1;
    nxt_lk.req_s1   = sys_ff.req_tgl;
    nxt_lk.req_s2   = lk_ff.req_s1;
    nxt_lk.req_prev = lk_ff.req_s2;
    // line-valid low and fields cleared when idle
    nxt_lk.lval     = 1'b0;
    nxt_lk.a        = 8'h00;
    nxt_lk.b        = 8'h00;
    nxt_lk.c        = 8'h00;
    case (lk_ff.st)
      lsvf_pkg::LK_IDLE: begin
        // config words stable while request pending
        if (lk_ff.req_s2 != lk_ff.req_prev) begin
          nxt_lk.st    = lsvf_pkg::LK_SEND;
          nxt_lk.mode  = sys_ff.sh_mode;
          nxt_lk.len   = sys_ff.sh_len;
          nxt_lk.idx   = 12'h000;
          nxt_lk.phase = 2'h0;
        end
      end
      lsvf_pkg::LK_SEND: begin
        nxt_lk.lval = 1'b1;
        case (lk_ff.mode)
          lsvf_pkg::MODE_RGB8: begin
            nxt_lk.a = pix_red_i[9:2];
            nxt_lk.b = pix_grn_i[9:2];
            nxt_lk.c = pix_blu_i[9:2];
          end
          lsvf_pkg::MODE_SP8: begin
            nxt_lk.a = lk_smp[9:2];
          end
          default: begin
            nxt_lk.a = lk_smp[7:0];
            nxt_lk.b = {6'h00, lk_smp[9:8]};
          end
        endcase
        // red, green, blue then next pixel
        if (lk_ff.mode != lsvf_pkg::MODE_RGB8 && lk_ff.phase != 2'h2) begin
          nxt_lk.phase = lk_ff.phase + 2'h1;
        end else begin
          nxt_lk.phase = 2'h0;
          nxt_lk.idx   = lk_ff.idx + 12'h001;
        end
        if (lk_last) begin
          nxt_lk.st      = lsvf_pkg::LK_IDLE;
          nxt_lk.ack_tgl = ~lk_ff.ack_tgl;
        end
      end
      default: begin
        nxt_lk.st = lsvf_pkg::LK_IDLE;
      end
    endcase
    if (lk_ff.rst_s2) begin
      nxt_lk          = '0;
      // keep the reset synchroniser running
      nxt_lk.rst_s1   = rst_i;
      nxt_lk.rst_s2   = lk_ff.rst_s1;
      nxt_lk.st       = lsvf_pkg::LK_IDLE;
      nxt_lk.len      = lsvf_pkg::LINE_PIX;
    end
  end

  // ---------------------------------------------------------------
  // link register and outputs
  // ---------------------------------------------------------------
  // transmitter inputs change on falling edge
  always_ff @(negedge pclk_i) begin
    lk_ff <= nxt_lk;
  end

  // fields are zero whenever line-valid is low
  assign lval_o    = lk_ff.lval;
  assign tx_a_o    = lk_ff.a;
  assign tx_b_o    = lk_ff.b;
  assign tx_c_o    = lk_ff.c;
  // index into the corrected line store
  assign pix_idx_o = lk_ff.idx;

endmodule // lsvf_top

`default_nettype wire
